// ### core/dcb_consts.svh
`ifndef DCB_CONSTS_SVH
`define DCB_CONSTS_SVH

// pointer register fields (bit 0 of the printed layout is the msb)
`define DCB_PTR_PEND 15
`define DCB_PTR_MSB 14
// control block word indices
`define DCB_W_OP 3'h0
`define DCB_W_UNIT 3'h1
`define DCB_W_CYL 3'h2
`define DCB_W_HEAD 3'h3
`define DCB_W_SECT 3'h4
`define DCB_W_COUNT 3'h5
`define DCB_W_BUF 3'h6
`define DCB_W_STAT 3'h7
// opcode field and codes
`define DCB_OP_FIELD 14:12
`define DCB_OP_FORMAT 3'h6
`define DCB_OP_RDREG 3'h5
`define DCB_OP_WRITE 3'h2
`define DCB_UNIT_FIELD 3:0
`define DCB_COUNT_FIELD 7:0
`define DCB_BLOCK_WORDS 16'h0004
// termination status bit indices
`define DCB_ST_DONE 15
`define DCB_ST_SUM 14
`define DCB_ST_ALT 10
`define DCB_ST_SYNC 9
`define DCB_ST_FMT 8
`define DCB_ST_SEEK 7
`define DCB_ST_DCRC 6
`define DCB_ST_ACRC 5
`define DCB_ST_NOID 4
`define DCB_ST_WP 3
`define DCB_ST_FLT 2
`define DCB_ST_NRDY 0
// drive status pin indices
`define DCB_DS_READY 0
`define DCB_DS_FLT 2
`define DCB_DS_WP 3
`define DCB_DS_SEEK 7
// drive register device codes
`define DCB_DEV_UNIT 6'h28
`define DCB_DEV_BUS 6'h29
`define DCB_DEV_TAG 6'h2a
`define DCB_TAG_FIELD 3:0
`endif

// ### core/dcb_engine.sv
`timescale 1ns/1ns
`include "dcb_consts.svh"
// disc control block engine: fetch block, move sectors, post status
module dcb_engine #(
  parameter int TRACK_SECTORS = 32,
  parameter int SECTOR_WORDS = 256,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ptr_wr_i,
  input wire logic [15:0] ptr_wdata_i,
  output logic [15:0] ptr_rdata_o,
  input wire logic drv_wr_i,
  input wire logic [5:0] drv_code_i,
  input wire logic [15:0] drv_wdata_i,
  output logic [15:0] drv_status_o,
  output logic [3:0] drv_unit_o,
  output logic [15:0] drv_bus_o,
  output logic [3:0] drv_tag_o,
  input wire logic [15:0] drv_pins_i,
  output dcb_pkg::dcb_mem_req_s mem_req_o,
  output logic mem_valid_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  output dcb_pkg::dcb_chan_job_s chan_job_o,
  output logic chan_start_o,
  input wire logic chan_evt_valid_i,
  input wire dcb_pkg::dcb_chan_evt_s chan_evt_i,
  input wire logic rd_valid_i,
  output logic rd_ready_o,
  input wire logic [15:0] rd_data_i,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [15:0] wr_data_o
);
  import dcb_pkg::*;

  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  dcb_state_e state_ff, nxt_state;
  logic [15:0] ptr_ff; // pointer register, msb is pending
  logic [15:0] blk_ff [0:6]; // local copy of words 0..6
  logic [2:0] widx_ff; // word index for fetch and alternate write
  logic [15:0] stat_ff; // accumulated error bits
  logic [15:0] cnt_ff; // memory words moved
  logic [15:0] total_ff; // memory words to move
  logic done_ff, abort_ff, alt_ff; // channel outcome flags
  dcb_mem_req_s mreq_ff, nxt_mreq;
  logic mvld_ff; // one access outstanding at most
  logic [3:0] unit_ff, tag_ff;
  logic [15:0] bus_ff;
  logic [15:0] ds; // synchronised drive status

  // ----------------------------------------
  // drive side registers and status pins
  // ----------------------------------------
  dcb_sync #(.W(16)) u_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .d_i(drv_pins_i),
    .q_o(ds)
  );
  assign drv_status_o = ds;
  assign drv_unit_o = unit_ff;
  assign drv_bus_o = bus_ff;
  assign drv_tag_o = tag_ff;
  // unit, bus and tag registers written by the host sequence
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      unit_ff <= 4'h0;
      bus_ff <= 16'h0000;
      tag_ff <= 4'h0;
    end else if (drv_wr_i) begin
      if (drv_code_i == `DCB_DEV_UNIT) unit_ff <= drv_wdata_i[`DCB_UNIT_FIELD];
      if (drv_code_i == `DCB_DEV_BUS) bus_ff <= drv_wdata_i;
      if (drv_code_i == `DCB_DEV_TAG) tag_ff <= drv_wdata_i[`DCB_TAG_FIELD];
    end
  end

  // ----------------------------------------
  // decode of the control block copy
  // ----------------------------------------
  wire [2:0] op = blk_ff[`DCB_W_OP][`DCB_OP_FIELD];
  wire is_fmt = (op == `DCB_OP_FORMAT);
  wire is_rr = (op == `DCB_OP_RDREG);
  wire dir_wr = is_fmt || (op == `DCB_OP_WRITE); // memory to disc
  wire [7:0] req_cnt = blk_ff[`DCB_W_COUNT][`DCB_COUNT_FIELD];
  // other operations always move exactly one sector
  wire [7:0] nsec = (is_fmt || is_rr) ? req_cnt : 8'h01;
  wire [15:0] spw = is_fmt ? `DCB_BLOCK_WORDS : 16'(SECTOR_WORDS);
  wire [15:0] buf_base = blk_ff[`DCB_W_BUF];
  wire [15:0] blk_base = {1'b0, ptr_ff[`DCB_PTR_MSB:0]};
  wire ptr_zero_wr = ptr_wr_i && (ptr_wdata_i == 16'h0000);
  wire ptr_go_wr = ptr_wr_i && (ptr_wdata_i != 16'h0000) && !ptr_wdata_i[`DCB_PTR_PEND];

  // ----------------------------------------
  // pre-transfer checks against the drive
  // ----------------------------------------
  // drive bits are only trusted when the selected unit is the block's unit
  wire unit_ok = (unit_ff == blk_ff[`DCB_W_UNIT][`DCB_UNIT_FIELD]);
  wire nrdy = !unit_ok || !ds[`DCB_DS_READY] || ds[`DCB_DS_FLT];
  wire flt = unit_ok && ds[`DCB_DS_FLT];
  wire skerr = unit_ok && ds[`DCB_DS_SEEK];
  wire wperr = unit_ok && ds[`DCB_DS_WP] && dir_wr;
  wire overcnt = (is_fmt || is_rr) && (32'(req_cnt) > TRACK_SECTORS);
  logic [15:0] chk_err;
  always_comb begin
    chk_err = 16'h0000;
    chk_err[`DCB_ST_NRDY] = nrdy;
    chk_err[`DCB_ST_FLT] = flt;
    chk_err[`DCB_ST_SEEK] = skerr;
    chk_err[`DCB_ST_WP] = wperr;
    chk_err[`DCB_ST_FMT] = overcnt;
  end

  // ----------------------------------------
  // channel outcome bits
  // ----------------------------------------
  logic [15:0] evt_err;
  always_comb begin
    evt_err = 16'h0000;
    evt_err[`DCB_ST_ALT] = chan_evt_i.alt;
    evt_err[`DCB_ST_SYNC] = chan_evt_i.sync_err;
    evt_err[`DCB_ST_FMT] = chan_evt_i.overrun;
    evt_err[`DCB_ST_DCRC] = chan_evt_i.data_crc;
    evt_err[`DCB_ST_ACRC] = chan_evt_i.hdr_crc;
    evt_err[`DCB_ST_NOID] = chan_evt_i.id_miss;
  end
  wire evt_in = (state_ff == ST_XFER) && chan_evt_valid_i;
  // final status: complete always, summary on any error
  logic [15:0] stat_word;
  always_comb begin
    stat_word = stat_ff;
    stat_word[`DCB_ST_DONE] = 1'b1;
    stat_word[`DCB_ST_SUM] = (stat_ff != 16'h0000);
  end

  // ----------------------------------------
  // data fifo between memory and channel
  // ----------------------------------------
  logic f_in_vld, f_in_rdy, f_out_vld, f_out_rdy;
  logic [15:0] f_in_data, f_out_data;
  dcb_fifo #(.W(16), .D(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .flush_i(state_ff != ST_XFER),
    .in_valid_i(f_in_vld),
    .in_ready_o(f_in_rdy),
    .in_data_i(f_in_data),
    .out_valid_o(f_out_vld),
    .out_ready_i(f_out_rdy),
    .out_data_o(f_out_data)
  );
  wire in_xfer = (state_ff == ST_XFER);
  wire mem_done = mvld_ff && mem_ack_i;
  // memory reads fill the fifo on writes, the channel fills it on reads
  assign f_in_vld = in_xfer && (dir_wr ? mem_done : rd_valid_i);
  assign f_in_data = dir_wr ? mem_rdata_i : rd_data_i;
  assign rd_ready_o = in_xfer && !dir_wr && f_in_rdy;
  assign wr_valid_o = in_xfer && dir_wr && f_out_vld;
  assign wr_data_o = f_out_data;

  // ----------------------------------------
  // memory access launch
  // ----------------------------------------
  wire go_fetch = (state_ff == ST_FETCH);
  // a read is only launched with fifo room, so its word always fits
  wire go_xw = in_xfer && dir_wr && (cnt_ff != total_ff) && f_in_rdy && !abort_ff;
  wire go_xr = in_xfer && !dir_wr && f_out_vld && !abort_ff;
  wire go_alt = (state_ff == ST_ALT);
  wire go_stat = (state_ff == ST_STAT);
  wire launch = !mvld_ff && (go_fetch || go_xw || go_xr || go_alt || go_stat);
  assign f_out_rdy = dir_wr ? (in_xfer && wr_ready_i) : (launch && go_xr);
  always_comb begin
    nxt_mreq = '0;
    if (go_fetch) begin
      nxt_mreq.addr = blk_base + {13'h0000, widx_ff};
    end else if (go_xw || go_xr) begin
      nxt_mreq.we = go_xr;
      nxt_mreq.addr = buf_base + cnt_ff;
      nxt_mreq.data = f_out_data;
    end else if (go_alt) begin
      nxt_mreq.we = 1'b1;
      nxt_mreq.addr = blk_base + {13'h0000, widx_ff};
      nxt_mreq.data = blk_ff[widx_ff];
    end else begin
      nxt_mreq.we = 1'b1;
      nxt_mreq.addr = blk_base + {13'h0000, `DCB_W_STAT};
      nxt_mreq.data = stat_word;
    end
  end
  assign mem_req_o = mreq_ff;
  assign mem_valid_o = mvld_ff;
  // request is held until acknowledged; a zero pointer write drops it
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mreq_ff <= '0;
      mvld_ff <= 1'b0;
    end else if (ptr_zero_wr || mem_done) begin
      mvld_ff <= 1'b0;
    end else if (launch) begin
      mreq_ff <= nxt_mreq;
      mvld_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  wire xfer_end = !mvld_ff && (abort_ff || (done_ff && (dir_wr || !f_out_vld)));
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (ptr_go_wr) nxt_state = ST_FETCH;
      ST_FETCH: if (mem_done && widx_ff == `DCB_W_BUF) nxt_state = ST_CHECK;
      ST_CHECK: nxt_state = (chk_err != 16'h0000) ? ST_STAT : ST_START;
      ST_START: nxt_state = ST_XFER;
      ST_XFER: if (xfer_end) nxt_state = alt_ff ? ST_ALT : ST_STAT;
      ST_ALT: if (mem_done && widx_ff == `DCB_W_HEAD) nxt_state = ST_STAT;
      ST_STAT: if (mem_done) nxt_state = ST_DONE;
      ST_DONE: nxt_state = ST_DONE;
      default: nxt_state = ST_IDLE;
    endcase
    if (ptr_zero_wr) nxt_state = ST_IDLE;
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) state_ff <= ST_IDLE;
    else state_ff <= nxt_state;
  end

  // ----------------------------------------
  // pointer register
  // ----------------------------------------
  // nonzero writes while busy are ignored; pending only after status lands
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr_ff <= 16'h0000;
    end else if (ptr_zero_wr) begin
      ptr_ff <= 16'h0000;
    end else if (ptr_go_wr && state_ff == ST_IDLE) begin
      ptr_ff <= ptr_wdata_i;
    end else if (state_ff == ST_STAT && mem_done) begin
      ptr_ff[`DCB_PTR_PEND] <= 1'b1;
    end
  end
  assign ptr_rdata_o = ptr_ff;

  // ----------------------------------------
  // block copy, counters and outcome flags
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 7; i++) blk_ff[i] <= 16'h0000;
    end else if (state_ff == ST_FETCH && mem_done) begin
      blk_ff[widx_ff] <= mem_rdata_i;
    end else if (evt_in && chan_evt_i.alt) begin
      blk_ff[`DCB_W_CYL] <= chan_evt_i.next_cyl;
      blk_ff[`DCB_W_HEAD] <= chan_evt_i.next_head;
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      widx_ff <= 3'h0;
      cnt_ff <= 16'h0000;
      total_ff <= 16'h0000;
      stat_ff <= 16'h0000;
      {done_ff, abort_ff, alt_ff} <= 3'b000;
    end else begin
      if (state_ff == ST_IDLE) begin
        widx_ff <= 3'h0;
        stat_ff <= 16'h0000;
        {done_ff, abort_ff, alt_ff} <= 3'b000;
      end else if ((state_ff == ST_FETCH || state_ff == ST_ALT) && mem_done) begin
        widx_ff <= widx_ff + 3'h1;
      end
      if (state_ff == ST_CHECK) begin
        stat_ff <= chk_err;
        total_ff <= 16'(nsec * spw);
        cnt_ff <= 16'h0000;
        widx_ff <= `DCB_W_CYL;
      end
      if (in_xfer && mem_done) cnt_ff <= cnt_ff + 16'h0001;
      if (evt_in) begin
        stat_ff <= stat_ff | evt_err;
        done_ff <= done_ff | chan_evt_i.done;
        abort_ff <= abort_ff | (evt_err != 16'h0000);
        alt_ff <= alt_ff | chan_evt_i.alt;
      end
    end
  end

  // ----------------------------------------
  // channel command
  // ----------------------------------------
  assign chan_start_o = (state_ff == ST_START);
  always_comb begin
    chan_job_o.op = op;
    chan_job_o.unit = blk_ff[`DCB_W_UNIT][`DCB_UNIT_FIELD];
    chan_job_o.cyl = blk_ff[`DCB_W_CYL];
    chan_job_o.head = blk_ff[`DCB_W_HEAD];
    chan_job_o.sector = blk_ff[`DCB_W_SECT];
    chan_job_o.count = nsec;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_PEND_AFTER_STAT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(ptr_ff[`DCB_PTR_PEND]) |-> $past(go_stat && mem_done && mreq_ff.we))
    else $error("pending set without a status write");
  AST_ZERO_IDLE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ptr_zero_wr |=> (ptr_ff == 16'h0000) && (state_ff == ST_IDLE) && !mvld_ff)
    else $error("zero write did not idle the controller");
  AST_START: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ptr_go_wr && state_ff == ST_IDLE |=> state_ff == ST_FETCH ##1 mvld_ff)
    else $error("start write did not begin the fetch");
  AST_IDLE_READ: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ptr_rdata_o == 16'h0000) == (state_ff == ST_IDLE))
    else $error("pointer zero does not match idle");
  AST_DONE_BIT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    mvld_ff && go_stat |-> mreq_ff.data[`DCB_ST_DONE]
      && (mreq_ff.addr == blk_base + {13'h0000, `DCB_W_STAT}))
    else $error("status write lacks complete bit");
  AST_SUMMARY: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    mvld_ff && go_stat |-> mreq_ff.data[`DCB_ST_SUM] == (mreq_ff.data[`DCB_ST_SUM-1:0] != '0))
    else $error("summary bit disagrees with error bits");
  AST_ONE_SECTOR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    state_ff == ST_START && !is_fmt && !is_rr |-> total_ff == 16'(SECTOR_WORDS))
    else $error("count used for an op that ignores it");
  AST_BUF_ADDR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    mvld_ff && in_xfer |-> mreq_ff.addr == blk_ff[`DCB_W_BUF] + cnt_ff)
    else $error("buffer address off");
  AST_TRACK_LIMIT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    state_ff == ST_CHECK && overcnt |=> state_ff == ST_STAT && stat_ff[`DCB_ST_FMT])
    else $error("oversized count not refused");
  AST_WPROT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    state_ff == ST_CHECK && wperr |=> !chan_start_o && stat_ff[`DCB_ST_WP])
    else $error("protected drive not refused");
  AST_ALT_COPY: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    evt_in && chan_evt_i.alt |=> blk_ff[`DCB_W_CYL] == $past(chan_evt_i.next_cyl)
      && alt_ff && abort_ff)
    else $error("alternate track not captured");
endmodule

// ### core/dcb_fifo.sv
`timescale 1ns/1ns
// small word fifo between memory and disc channel
module dcb_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [0:D-1]; // storage
  logic [AW-1:0] wp_ff, rp_ff;
  logic [AW:0] cnt_ff; // fill level, honest full and empty
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_ff != (AW+1)'(D));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem_ff[rp_ff];
  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else if (flush_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wp_ff <= (wp_ff == AW'(D-1)) ? '0 : wp_ff + 1'b1;
      if (pop) rp_ff <= (rp_ff == AW'(D-1)) ? '0 : rp_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // data words only, no reset needed
  always_ff @(posedge clk_sys_i) begin
    if (push) mem_ff[wp_ff] <= in_data_i;
  end
endmodule

// ### core/dcb_pkg.sv
package dcb_pkg;
  // controller sequencing states
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_CHECK, ST_START, ST_XFER, ST_ALT, ST_STAT, ST_DONE
  } dcb_state_e;
  // one memory word access
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] data;
  } dcb_mem_req_s;
  // operation handed to the disc channel
  typedef struct packed {
    logic [2:0] op;
    logic [3:0] unit;
    logic [15:0] cyl;
    logic [15:0] head;
    logic [15:0] sector;
    logic [7:0] count;
  } dcb_chan_job_s;
  // outcome reported by the disc channel
  typedef struct packed {
    logic done;
    logic alt;
    logic sync_err;
    logic overrun;
    logic hdr_crc;
    logic data_crc;
    logic id_miss;
    logic [15:0] next_cyl;
    logic [15:0] next_head;
  } dcb_chan_evt_s;
endpackage

// ### core/dcb_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for pin inputs
module dcb_sync #(
  parameter int W = 16
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff; // first stage, read only by q_o
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_ff <= '0;
      q_o <= '0;
    end else begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule

// ### test/dcb_far_model.sv
`timescale 1ns/1ns
// far side stand-in: word memory plus a disc channel that streams words
module dcb_far_model
  import dcb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic slow_i,
  input wire dcb_pkg::dcb_chan_evt_s tmpl_i,
  input wire dcb_pkg::dcb_mem_req_s mem_req_i,
  input wire logic mem_valid_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o,
  input wire dcb_pkg::dcb_chan_job_s job_i,
  input wire logic start_i,
  output logic evt_valid_o,
  output dcb_pkg::dcb_chan_evt_s evt_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [15:0] rd_data_o,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [15:0] wr_data_i
);
  logic [15:0] mem [0:255]; // word store, preloaded by the bench
  logic [15:0] wbuf [0:255]; // words taken off the write stream
  logic [15:0] q_ff; // last word read out
  logic [1:0] wait_ff; // ack latency count
  logic [9:0] k_ff; // words moved so far
  logic [9:0] n_ff; // words due for this operation
  logic act_ff, rv_ff, ph_ff, isrd_ff;
  dcb_chan_job_s job_ff; // job taken at the last start, read by the bench
  wire err = |tmpl_i[37:32]; // any alt or error flag aborts at once
  // -----------------------------------------------
  // released lines show the inverse, never the last value
  // -----------------------------------------------
  assign mem_rdata_o = mem_ack_o ? q_ff : ~q_ff;
  assign rd_data_o = rv_ff ? 16'ha000 + 16'(k_ff) : 16'h5fff - 16'(k_ff);
  assign rd_valid_o = rv_ff;
  // slow mode stalls the write stream every other cycle
  assign wr_ready_o = act_ff & ~isrd_ff & (~slow_i | ph_ff);
  // memory: one access, acked at once or after three waits
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_ack_o <= 1'b0;
      q_ff <= 16'h0;
      wait_ff <= 2'h0;
    end else if (mem_valid_i && !mem_ack_o && (!slow_i || wait_ff == 2'h3)) begin
      mem_ack_o <= 1'b1;
      wait_ff <= 2'h0;
      q_ff <= mem[mem_req_i.addr[7:0]];
      if (mem_req_i.we) mem[mem_req_i.addr[7:0]] <= mem_req_i.data;
    end else begin
      mem_ack_o <= 1'b0;
      wait_ff <= mem_valid_i ? wait_ff + 2'h1 : 2'h0;
    end
  end
  // channel: count words, valid held until ready, event at the end
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {act_ff, rv_ff, ph_ff, isrd_ff, evt_valid_o} <= 5'h0;
      {k_ff, n_ff} <= 20'h0;
      evt_o <= '0;
      job_ff <= '0;
    end else begin
      ph_ff <= ~ph_ff;
      evt_valid_o <= 1'b0;
      if (start_i) begin
        {act_ff, rv_ff, k_ff} <= {2'b10, 10'h0};
        job_ff <= job_i;
        isrd_ff <= job_i.op != 3'h2 && job_i.op != 3'h6;
        n_ff <= (job_i.op == 3'h5 || job_i.op == 3'h6) ? {job_i.count, 2'h0} : 10'h4;
      end else if (act_ff && (err || k_ff == n_ff)) begin
        act_ff <= 1'b0;
        evt_valid_o <= 1'b1;
        evt_o <= {!err, tmpl_i[37:0]};
      end else if (act_ff && isrd_ff) begin
        if (rv_ff && rd_ready_i) {rv_ff, k_ff} <= {1'b0, k_ff + 10'h1};
        else if (!rv_ff && (!slow_i || ph_ff)) rv_ff <= 1'b1;
      end else if (wr_valid_i && wr_ready_o) begin
        wbuf[k_ff[7:0]] <= wr_data_i;
        k_ff <= k_ff + 10'h1;
      end
    end
  end
endmodule

// ### test/disc_control_block_engine_tb_top.sv
`timescale 1ns/1ns
// bench: block at 16'h0010, buffer at 16'h0040, unit 3 selected
module disc_control_block_engine_tb_top;
  import dcb_pkg::*;
  typedef struct packed {
    logic [2:0] op; logic [7:0] cnt; logic [15:0] pins; logic [5:0] fl; logic slow;
    logic [15:0] exp;
  } dcb_row_s;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ptr_wr, drv_wr, slow, rv, rr, wv, wrdy, mv, mack, cst, ev;
  logic [5:0] dcode;
  logic [15:0] pwd, prd, dwd, dst, dbus, pins, mrd, rdd, wrd;
  logic [3:0] dunit, dtag;
  dcb_mem_req_s mreq;
  dcb_chan_job_s job;
  dcb_chan_evt_s evt, tmpl;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  // ordinary cases: op, count, drive pins, channel flags, slow, status
  dcb_row_s rows [0:14] = '{
    '{3'h1, 8'h1, 16'h1, 6'h00, 1'b0, 16'h8000},
    '{3'h5, 8'h2, 16'h1, 6'h00, 1'b1, 16'h8000},
    '{3'h2, 8'h9, 16'h1, 6'h00, 1'b1, 16'h8000},
    '{3'h6, 8'h20, 16'h1, 6'h00, 1'b0, 16'h8000},
    '{3'h5, 8'h21, 16'h1, 6'h00, 1'b0, 16'hc100},
    '{3'h1, 8'h1, 16'h1, 6'h10, 1'b0, 16'hc200},
    '{3'h6, 8'h1, 16'h1, 6'h08, 1'b0, 16'hc100},
    '{3'h1, 8'h1, 16'h1, 6'h04, 1'b0, 16'hc020},
    '{3'h1, 8'h1, 16'h1, 6'h02, 1'b1, 16'hc040},
    '{3'h0, 8'h1, 16'h1, 6'h01, 1'b0, 16'hc010},
    '{3'h2, 8'h1, 16'h9, 6'h00, 1'b0, 16'hc008},
    '{3'h6, 8'h1, 16'h9, 6'h00, 1'b0, 16'hc008},
    '{3'h1, 8'h1, 16'h5, 6'h00, 1'b0, 16'hc005},
    '{3'h1, 8'h1, 16'h81, 6'h00, 1'b0, 16'hc080},
    '{3'h1, 8'h1, 16'h0, 6'h00, 1'b0, 16'hc001}};
  dcb_row_s r;
  always #10 clk_sys_i = ~clk_sys_i;
  // hang guard, well above the longest expected run
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize;
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // strobes rise at a falling edge, drop one cycle later, one idle cycle after
  task automatic ptr_w(input logic [15:0] d);
    {ptr_wr, pwd} = {1'b1, d};
    @(negedge clk_sys_i);
    ptr_wr = 1'b0;
    @(negedge clk_sys_i);
  endtask
  task automatic drv_w(input logic [5:0] c, input logic [15:0] d);
    {drv_wr, dcode, dwd} = {1'b1, c, d};
    @(negedge clk_sys_i);
    drv_wr = 1'b0;
    @(negedge clk_sys_i);
  endtask
  // build the block in memory, then start it
  task automatic start_op(input dcb_row_s x);
    for (int i = 0; i < 128; i++) begin
      dcb_far_model_inst.mem[8'h40 + i] = 16'h5000 + 16'(i);
      dcb_far_model_inst.wbuf[i] = 16'h0;
    end
    dcb_far_model_inst.mem[8'h10] = {1'b0, x.op, 12'h0};
    dcb_far_model_inst.mem[8'h11] = 16'h0003;
    dcb_far_model_inst.mem[8'h12] = 16'h0005;
    dcb_far_model_inst.mem[8'h13] = 16'h0002;
    dcb_far_model_inst.mem[8'h14] = 16'h0000;
    dcb_far_model_inst.mem[8'h15] = {8'h0, x.cnt};
    dcb_far_model_inst.mem[8'h16] = 16'h0040;
    dcb_far_model_inst.mem[8'h17] = 16'hffff;
    {tmpl, slow, pins} = {1'b0, x.fl, 16'h0123, 16'h0004, x.slow, x.pins};
    repeat (3) @(negedge clk_sys_i);
    ptr_w(16'h0010);
  endtask
  // wait for pending, check status and data, then release the engine
  task automatic finish(input dcb_row_s x);
    int n;
    n = (x.op == 3'h5 || x.op == 3'h6) ? {x.cnt, 2'h0} : 4;
    for (int k = 0; k < 4000 && prd !== 16'h8010; k++) @(negedge clk_sys_i);
    chk(prd, 16'h8010);
    chk({dcb_far_model_inst.job_ff.unit, dcb_far_model_inst.job_ff.sector[3:0],
      dcb_far_model_inst.job_ff.cyl[3:0], dcb_far_model_inst.job_ff.head[3:0]}, 16'h3052);
    chk(dcb_far_model_inst.mem[8'h17], x.exp);
    for (int i = 0; i < n && x.exp == 16'h8000; i++)
      if (x.op == 3'h2 || x.op == 3'h6) chk(dcb_far_model_inst.wbuf[i], 16'h5000 + 16'(i));
      else chk(dcb_far_model_inst.mem[8'h40 + i], 16'ha000 + 16'(i));
    ptr_w(16'h0000);
    chk(prd, 16'h0000);
  endtask
  initial begin
    {ptr_wr, drv_wr, slow, dcode, pwd, dwd, pins, tmpl} = '0;
    repeat (6) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    chk(prd, 16'h0000);
    chk({15'h0, mv}, 16'h0000);
    drv_w(6'h28, 16'h0003);
    drv_w(6'h2a, 16'h0001);
    chk({8'h0, dunit, dtag}, 16'h0031);
    drv_w(6'h2a, 16'h0005);
    drv_w(6'h29, 16'h0123);
    drv_w(6'h2a, 16'h0003);
    chk({12'h0, dtag} ^ dbus, 16'h0120);
    drv_w(6'h2a, 16'h0005);
    drv_w(6'h29, 16'h0040);
    drv_w(6'h2a, 16'h0009);
    chk({12'h0, dtag} ^ dbus, 16'h0049);
    drv_w(6'h29, 16'h0010);
    chk({12'h0, dtag} ^ dbus, 16'h0019);
    drv_w(6'h2a, 16'h0001);
    pins = 16'h0001;
    repeat (3) @(negedge clk_sys_i);
    chk(dst, 16'h0001);
    for (int i = 0; i < 15; i++) begin
      start_op(rows[i]);
      finish(rows[i]);
    end
    ptr_w(16'h8010);
    chk(prd, 16'h0000);
    start_op(rows[1]);
    ptr_w(16'h0020);
    finish(rows[1]);
    start_op(rows[2]);
    repeat (5) @(negedge clk_sys_i);
    ptr_w(16'h0000);
    repeat (20) @(negedge clk_sys_i);
    chk(prd ^ {15'h0, mv}, 16'h0000);
    r = '{3'h1, 8'h1, 16'h1, 6'h20, 1'b0, 16'hc400};
    start_op(r);
    finish(r);
    chk(dcb_far_model_inst.mem[8'h12], 16'h0123);
    chk(dcb_far_model_inst.mem[8'h13], 16'h0004);
    drv_w(6'h28, 16'h0005);
    r = '{3'h1, 8'h1, 16'h85, 6'h00, 1'b0, 16'hc001};
    start_op(r);
    finish(r);
    summarize();
  end
  dcb_engine #(.SECTOR_WORDS(4)) dcb_engine_inst (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ptr_wr_i(ptr_wr), .ptr_wdata_i(pwd),
    .ptr_rdata_o(prd), .drv_wr_i(drv_wr), .drv_code_i(dcode), .drv_wdata_i(dwd),
    .drv_status_o(dst), .drv_unit_o(dunit), .drv_bus_o(dbus), .drv_tag_o(dtag),
    .drv_pins_i(pins), .mem_req_o(mreq), .mem_valid_o(mv), .mem_ack_i(mack),
    .mem_rdata_i(mrd), .chan_job_o(job), .chan_start_o(cst), .chan_evt_valid_i(ev),
    .chan_evt_i(evt), .rd_valid_i(rv), .rd_ready_o(rr), .rd_data_i(rdd),
    .wr_valid_o(wv), .wr_ready_i(wrdy), .wr_data_o(wrd));
  dcb_far_model dcb_far_model_inst (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .slow_i(slow), .tmpl_i(tmpl),
    .mem_req_i(mreq), .mem_valid_i(mv), .mem_ack_o(mack), .mem_rdata_o(mrd),
    .job_i(job), .start_i(cst), .evt_valid_o(ev), .evt_o(evt), .rd_valid_o(rv),
    .rd_ready_i(rr), .rd_data_o(rdd), .wr_valid_i(wv), .wr_ready_o(wrdy), .wr_data_i(wrd));
endmodule
